// File: logic/fsr_pkg.sv
// package for the floppy status and rate register block
package fsr_pkg;
  // register word indices; each register owns one aligned 32-bit word,
  // so its AXI4-Lite byte address is four times the index
  localparam int FSR_TAPE_IDX   = 3;
  localparam int FSR_STATUS_IDX = 4;
  localparam int FSR_CFG_IDX    = 6; // free slot picked for config
  localparam int FSR_CCR_IDX    = 7;
  localparam logic [4:0] FSR_TAPE_ADDR   = 5'(4 * FSR_TAPE_IDX);
  localparam logic [4:0] FSR_STATUS_ADDR = 5'(4 * FSR_STATUS_IDX);
  localparam logic [4:0] FSR_CFG_ADDR    = 5'(4 * FSR_CFG_IDX);
  localparam logic [4:0] FSR_CCR_ADDR    = 5'(4 * FSR_CCR_IDX);

  // rate register fields and reset value
  localparam logic [7:0] FSR_RATE_RESET = 8'h02;
  localparam int FSR_RATE_LO   = 0;
  localparam int FSR_PRE_LO    = 2;
  localparam int FSR_LOWPWR    = 6;
  localparam int FSR_SWRST     = 7;

  // status register bit positions
  localparam int FSR_ST_BUSY   = 4;
  localparam int FSR_ST_NONDMA = 5;
  localparam int FSR_ST_DIO    = 6;
  localparam int FSR_ST_RQM    = 7;

  // config register fields
  localparam int FSR_CFG_TYPE_LO = 0;
  localparam int FSR_CFG_BOOT_LO = 8;
  localparam int FSR_CFG_MODE    = 10;
  localparam int FSR_CFG_IDENT   = 11;
  localparam int FSR_CFG_DRT_LO  = 12;

  localparam logic [2:0] FSR_PRE_OFF = 3'h7;
  localparam logic [2:0] FSR_PRE_DEF = 3'h0;
  localparam logic [2:0] FSR_PRE_1M  = 3'h1; // 41.67 ns step
  localparam logic [2:0] FSR_PRE_STD = 3'h3; // 125 ns
  localparam logic [1:0] FSR_AXI_OK     = 2'h0;
  localparam logic [1:0] FSR_AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FSR_R250  = 3'b000,
    FSR_R300  = 3'b001,
    FSR_R500  = 3'b010,
    FSR_R1M   = 3'b011,
    FSR_R2M   = 3'b100
  } fsr_rate_t;
endpackage

// File: logic/fsr_regs.sv
// floppy status, tape and rate register bank with AXI4-Lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// [R01] normal mode: tape register holds two r/w bits; upper bits read zero on bus
// [R02] enhanced mode: tape bits 7:6 reserved, ignore writes, read zero
// [R03] enhanced mode: tape bits 5:4 are drive type pair picked by drive select
// [R04] enhanced mode: tape bits 3:2 mirror boot drive config bits 1:0
// [R05] status register at offset 4, read-only, readable any time, no wait
// [R06] host should poll status before each data byte unless using DMA
// [R07] status bits 3:0 high while matching drive seeks
// [R08] status bit 4 high while a command is in progress
// [R09] status bit 5 high during polled non-DMA execution phase
// [R10] status bit 6 gives transfer direction, one means host reads
// [R11] status bit 7 high means host may move a data byte
// [R12] rate register write-only at offset 4; last rate write wins
// [R13] rate register survives soft reset; hard reset loads 02H
// [R14] rate bits 4:2 select precompensation, 111 off, 000 default
// [R15] default precompensation is 41.67 ns at 1 Mbps, else 125 ns
// [R16] precompensation starts at track zero unless configure reprograms it
// [R17] software writes zero to rate register bit 5
// [R18] rate bit 6 enters low power; soft reset or data/status access exits
// [R19] rate bit 7 requests controller soft reset, then clears itself
// [R20] rate decoded from drive-rate field and two select bits
// [R21] density output follows rate and identity option; hard reset sets high
module fsr_regs (
  input  wire logic        ref_clk,      // 200 MHz clock
  input  wire logic        rst,          // hardware reset, sync high
  input  wire logic        clkEn,        // freezes all state when low
  input  wire logic [4:0]  awaddr,       // AXI write address
  input  wire logic        awvalid,      // AXI write address valid
  output logic             awready,      // AXI write address ready
  input  wire logic [31:0] wdata,        // AXI write data
  input  wire logic [3:0]  wstrb,        // AXI byte strobes
  input  wire logic        wvalid,       // AXI write data valid
  output logic             wready,       // AXI write data ready
  output logic [1:0]       bresp,        // AXI write response
  output logic             bvalid,       // AXI write response valid
  input  wire logic        bready,       // AXI write response ready
  input  wire logic [4:0]  araddr,       // AXI read address
  input  wire logic        arvalid,      // AXI read address valid
  output logic             arready,      // AXI read address ready
  output logic [31:0]      rdata,        // AXI read data
  output logic [1:0]       rresp,        // AXI read response
  output logic             rvalid,       // AXI read valid
  input  wire logic        rready,       // AXI read ready
  input  wire logic [3:0]  driveSeeking, // per-drive seek, core logic
  input  wire logic        cmdBusy,      // command in progress
  input  wire logic        nonDmaExec,   // polled execution phase
  input  wire logic        transferDir,  // 1: host reads data
  input  wire logic        hostRequest,  // data register ready
  input  wire logic [1:0]  driveSelect,  // last drive select
  input  wire logic        dataAccess,   // data register access
  input  wire logic        precompSet,   // configure start track
  input  wire logic [7:0]  precompTrkIn, // new start track
  output logic             softReset,    // one-cycle soft reset pulse
  output logic             lowPower,     // manual low power level
  output logic [2:0]      writeShiftCode,// effective precomp step
  output logic [2:0]       rateSel,      // decoded fsr_rate_t
  output logic [7:0]       precompTrack, // precomp start track
  output logic             densityOutput // density pin level
);
  import fsr_pkg::*;

  typedef struct packed {
    logic        awSeen;
    logic [4:0]  awAddr;
    logic        wSeen;
    logic [31:0] wDat;
    logic [3:0]  wStb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rDat;
    logic [1:0]  rResp;
    logic [7:0]  rate;
    logic [1:0]  rateCode;
    logic [1:0]  tapeNum;
    logic [15:0] cfg;
    logic        swRst;
    logic        lowPwr;
    logic [7:0]  trk;
    logic        dens;
  } fsr_state_t;

  fsr_state_t st_r;
  fsr_state_t st_nxt;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic fsr_rate_t decodeRate(input logic [1:0] drt,
                                           input logic [1:0] sel);
    fsr_rate_t r;
    case (sel)
      2'b11:   r = FSR_R1M;
      2'b00:   r = FSR_R500;
      2'b10:   r = FSR_R250;
      2'b01: begin
        case (drt)
          2'b01:   r = FSR_R500;
          2'b10:   r = FSR_R2M;
          default: r = FSR_R300;
        endcase
      end
      default: r = FSR_R250;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] wordByte(input logic [31:0] d,
                                          input logic [7:0] old,
                                          input logic s);
    return s ? d[7:0] : old;
  endfunction

  fsr_rate_t curRate;
  logic      enhMode;
  logic [7:0] tapeRead;
  logic [7:0] statusRead;
  logic [1:0] typePair;

  always_comb begin
    curRate = decodeRate(st_r.cfg[FSR_CFG_DRT_LO +: 2], st_r.rateCode); // R20
    enhMode = st_r.cfg[FSR_CFG_MODE];
    case (driveSelect)                                               // R03
      2'b00:   typePair = st_r.cfg[FSR_CFG_TYPE_LO     +: 2];
      2'b01:   typePair = st_r.cfg[FSR_CFG_TYPE_LO + 2 +: 2];
      2'b10:   typePair = st_r.cfg[FSR_CFG_TYPE_LO + 4 +: 2];
      default: typePair = st_r.cfg[FSR_CFG_TYPE_LO + 6 +: 2];
    endcase
    // no tri-state on an AXI bus, so undriven bits read as zero
    if (enhMode) begin
      tapeRead = {2'b00, typePair,                                   // R02 R03
                  st_r.cfg[FSR_CFG_BOOT_LO +: 2], st_r.tapeNum};     // R04
    end else begin
      tapeRead = {6'h00, st_r.tapeNum};                              // R01
    end
    statusRead = {hostRequest, transferDir, nonDmaExec, cmdBusy,     // R10 R11
                  driveSeeking};                                     // R07 R08 R09
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic doWrite;
  logic doRead;

  always_comb begin
    st_nxt  = st_r;
    doWrite = st_r.awSeen && st_r.wSeen && !st_r.bValid;
    doRead  = arvalid && !st_r.rValid;
    st_nxt.swRst = 1'b0;                                             // R19

    if (awvalid && !st_r.awSeen) begin
      st_nxt.awSeen = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && !st_r.wSeen) begin
      st_nxt.wSeen = 1'b1;
      st_nxt.wDat  = wdata;
      st_nxt.wStb  = wstrb;
    end
    if (st_r.bValid && bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (st_r.rValid && rready) begin
      st_nxt.rValid = 1'b0;
    end

    if (doWrite) begin
      st_nxt.awSeen = 1'b0;
      st_nxt.wSeen  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = FSR_AXI_OK;
      case (st_r.awAddr)
        FSR_STATUS_ADDR: begin
          if (st_r.wStb[0]) begin
            st_nxt.rate = wordByte(st_r.wDat, st_r.rate, 1'b1);     // R12
            st_nxt.rate[FSR_SWRST] = 1'b0;                           // R19
            st_nxt.rateCode = st_r.wDat[FSR_RATE_LO +: 2];           // R12
            st_nxt.swRst = st_r.wDat[FSR_SWRST];                     // R19
            if (st_r.wDat[FSR_LOWPWR]) begin
              st_nxt.lowPwr = 1'b1;                                  // R18
            end
          end
        end
        FSR_TAPE_ADDR: begin
          if (st_r.wStb[0]) begin
            st_nxt.tapeNum = st_r.wDat[1:0];                         // R01 R02
          end
        end
        FSR_CCR_ADDR: begin
          if (st_r.wStb[0]) begin
            st_nxt.rateCode = st_r.wDat[1:0];                        // R12
          end
        end
        FSR_CFG_ADDR: begin
          if (st_r.wStb[0]) st_nxt.cfg[7:0]  = st_r.wDat[7:0];
          if (st_r.wStb[1]) st_nxt.cfg[15:8] = st_r.wDat[15:8];
        end
        default: st_nxt.bResp = FSR_AXI_SLVERR;
      endcase
    end

    if (doRead) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = FSR_AXI_OK;
      case (araddr)
        FSR_STATUS_ADDR: begin
          st_nxt.rDat   = {24'h000000, statusRead};                  // R05
          st_nxt.lowPwr = 1'b0;                                      // R18
        end
        FSR_TAPE_ADDR: st_nxt.rDat = {24'h000000, tapeRead};
        FSR_CFG_ADDR:  st_nxt.rDat = {16'h0000, st_r.cfg};
        default: begin
          st_nxt.rDat  = 32'h00000000;
          st_nxt.rResp = FSR_AXI_SLVERR;
        end
      endcase
    end

    // data access or soft reset wakes from low power
    if (dataAccess || st_r.swRst) begin
      st_nxt.lowPwr = 1'b0;                                          // R18
    end
    if (st_r.swRst) begin
      st_nxt.trk = 8'h00;                                            // R16
    end
    if (precompSet) begin
      st_nxt.trk = precompTrkIn;                                     // R16
    end

    // density: high at 1M/500 when ident set, inverted otherwise
    st_nxt.dens = ((curRate == FSR_R1M) || (curRate == FSR_R500))
                  ~^ st_r.cfg[FSR_CFG_IDENT];                        // R21
  end

  // ------------------------------------------------------------
  // state register; hard reset only here, soft reset keeps rate
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r          <= '0;
      st_r.rate     <= FSR_RATE_RESET;                               // R13
      st_r.rateCode <= FSR_RATE_RESET[1:0];                          // R13
      st_r.dens     <= 1'b1;                                         // R21
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // effective precomp step from code and rate
  logic [2:0] preCode;
  assign preCode = st_r.rate[FSR_PRE_LO +: 3];

  logic [2:0] shift_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_r <= FSR_PRE_STD;
    end else if (clkEn) begin
      if (preCode == FSR_PRE_OFF) begin
        shift_r <= 3'h0;                                             // R14
      end else if (preCode == FSR_PRE_DEF) begin
        shift_r <= (curRate == FSR_R1M) ? FSR_PRE_1M : FSR_PRE_STD;  // R15
      end else begin
        shift_r <= preCode;                                          // R14
      end
    end
  end

  assign awready        = !st_r.awSeen;
  assign wready         = !st_r.wSeen;
  assign bvalid         = st_r.bValid;
  assign bresp          = st_r.bResp;
  assign arready        = !st_r.rValid;
  assign rvalid         = st_r.rValid;
  assign rdata          = st_r.rDat;
  assign rresp          = st_r.rResp;
  assign softReset      = st_r.swRst;
  assign lowPower       = st_r.lowPwr;
  assign writeShiftCode = shift_r;
  assign rateSel        = curRate;
  assign precompTrack   = st_r.trk;
  assign densityOutput  = st_r.dens;
endmodule // fsr_regs

// File: verif/fsr_host_model.sv
// host-side AXI4-Lite master model for the floppy register bank
`timescale 1ns/1ps
module fsr_host_model (
  input  wire logic        ref_clk,                 // bus clock
  output logic [4:0]       awaddr, araddr,          // byte addresses
  output logic [3:0]       wstrb,                   // write strobes
  output logic [31:0]      wdata,                   // write data
  output logic             awvalid, wvalid, bready, // write side
  output logic             arvalid, rready,         // read side
  input  wire logic        awready, wready, bvalid, // write answers
  input  wire logic        arready, rvalid,         // read answers
  input  wire logic [31:0] rdata,                   // read data
  input  wire logic [1:0]  bresp,                   // write response
  input  wire logic [1:0]  rresp                    // read response
);
  logic [1:0] wrResp;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
  end
  // released payload shows the inverse so stale values cannot pass
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!(bvalid && bready));
    wrResp = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // fsr_host_model

// File: verif/fsr_regs_checker.sv
// assertion checker for the floppy status and rate register bank
`timescale 1ns/1ps
module fsr_regs_checker
  import fsr_pkg::*;
(
  input wire logic        ref_clk, rst, clkEn,           // clock, reset, enable
  input wire logic [4:0]  araddr,                        // read address
  input wire logic [3:0]  driveSeeking,                  // seek flags
  input wire logic        arvalid, arready, rvalid,      // read handshake
  input wire logic        rready, bvalid, bready,        // answers
  input wire logic        awready, wready,               // write readies
  input wire logic [31:0] rdata,                         // read data
  input wire logic [1:0]  rresp,                         // read response
  input wire logic        cmdBusy, nonDmaExec,           // core flags
  input wire logic        transferDir, hostRequest,      // core flags
  input wire logic        dataAccess, precompSet,        // core pulses
  input wire logic [7:0]  precompTrkIn, precompTrack,    // start track
  input wire logic        softReset, lowPower,           // control outs
  input wire logic [2:0]  writeShiftCode                 // precomp step
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence statusRd;
    arvalid && arready && araddr == FSR_STATUS_ADDR && clkEn;
  endsequence
  pulse_once_a: assert property (softReset |=> !softReset)
    else $error("soft reset pulse longer than one cycle");
  reset_idle_a: assert property ($fell(rst) |-> awready && wready
    && arready && !bvalid && !rvalid) else $error("bus not idle");
  stat_seek_a: assert property (statusRd |=> rvalid
    && rdata[3:0] == $past(driveSeeking)) else $error("seek bits wrong");
  stat_flags_a: assert property (statusRd |=>
    rdata[7:4] == {$past(hostRequest), $past(transferDir),
    $past(nonDmaExec), $past(cmdBusy)}) else $error("status flags wrong");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  wake_data_a: assert property (dataAccess && clkEn |=> !lowPower)
    else $error("low power kept after data access");
  wake_stat_a: assert property (statusRd |-> ##[1:2] !lowPower)
    else $error("low power kept after status read");
  track_load_a: assert property (precompSet && clkEn |=>
    precompTrack == $past(precompTrkIn)) else $error("track not loaded");
  shift_code_a: assert property (writeShiftCode != 3'h7)
    else $error("shift code out of range");
  cover property (softReset);
  cover property ($rose(lowPower));
  cover property (rvalid && rresp == FSR_AXI_SLVERR);
endmodule // fsr_regs_checker

bind fsr_regs fsr_regs_checker chk_i (.*);

// File: verif/fsr_regs_tb.sv
// self-checking bench for the floppy status and rate registers
`timescale 1ns/1ps
module fsr_regs_tb;
  import fsr_pkg::*;
  logic ref_clk = 0, rst = 1, clkEn = 1, dataAccess = 0, precompSet = 0;
  logic [4:0] awaddr, araddr;
  logic [3:0] wstrb, driveSeeking = 0;
  logic [31:0] wdata, rdata, d, cfg, rnd = 32'h1a95;
  logic [1:0] bresp, rresp, resp, driveSelect = 0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, softReset, lowPower;
  logic cmdBusy = 0, nonDmaExec = 0, transferDir = 0, hostRequest = 0;
  logic densityOutput;
  logic [2:0] writeShiftCode, rateSel;
  logic [7:0] precompTrkIn = 0, precompTrack;
  fsr_rate_t r;
  int error_cnt = 0, num_checks = 0, swCnt = 0, drt, sel, id, c;

  fsr_regs uut (.*);
  fsr_host_model host (.*);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (softReset) swCnt++;

  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic fsr_rate_t erate(int dr, int s);
    if (s == 3) return FSR_R1M;
    if (s == 0) return FSR_R500;
    if (s == 2) return FSR_R250;
    if (dr == 0) return FSR_R300;
    return (dr == 1) ? FSR_R500 : FSR_R2M;
  endfunction
  function automatic logic [2:0] eshift(int k, fsr_rate_t q);
    if (k == 7) return 3'h0;
    if (k != 0) return 3'(k);
    return (q == FSR_R1M) ? 3'h1 : 3'h3;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    results;
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    repeat (2) @(posedge ref_clk);
    chk("rate", FSR_R250, rateSel);
    chk("shift", 3'h3, writeShiftCode);
    chk("dens", 1'b1, densityOutput);
    repeat (6) begin
      rnd = nx(rnd);
      {hostRequest, transferDir, nonDmaExec, cmdBusy, driveSeeking} <= rnd[7:0];
      host.rd(FSR_STATUS_ADDR, d, resp);
      chk("status", {24'h0, rnd[7:0]}, d);
      host.wr(FSR_TAPE_ADDR, rnd);
      host.rd(FSR_TAPE_ADDR, d, resp);
      chk("tape", rnd & 32'h3, d);
    end
    host.rd(5'h00, d, resp);
    chk("resp", FSR_AXI_SLVERR, resp);
    chk("rdata", 32'h0, d);
    host.wr(5'h00, 32'h0);
    chk("bresp", FSR_AXI_SLVERR, host.wrResp);
    host.wr(FSR_CCR_ADDR, 32'h2);
    chk("bresp", FSR_AXI_OK, host.wrResp);
    for (c = 0; c < 4; c++) begin
      rnd = nx(rnd);
      cfg = (rnd & 32'h3FF) | 32'h400;
      driveSelect <= 2'(c);
      host.wr(FSR_CFG_ADDR, cfg);
      host.wr(FSR_TAPE_ADDR, 32'hFF);
      host.rd(FSR_TAPE_ADDR, d, resp);
      chk("etape", {26'h0, cfg[2*c +: 2], cfg[9:8], 2'h3}, d);
    end
    for (drt = 0; drt < 3; drt++)
      for (id = 0; id < 2; id++)
        for (sel = 0; sel < 4; sel++) begin
          r = erate(drt, sel);
          host.wr(FSR_CFG_ADDR, 32'((drt << 12) | (id << 11)));
          host.wr(FSR_STATUS_ADDR, 32'(sel));
          chk("rate", r, rateSel);
          chk("shift", eshift(0, r), writeShiftCode);
          chk("dens", ((r == FSR_R1M) || (r == FSR_R500)) == id,
              densityOutput);
        end
    host.wr(FSR_CCR_ADDR, 32'h3);
    chk("ccr", FSR_R1M, rateSel);
    for (c = 0; c < 8; c++) begin
      host.wr(FSR_STATUS_ADDR, 32'((c << 2) | 3));
      chk("shift", eshift(c, FSR_R1M), writeShiftCode);
    end
    host.wr(FSR_STATUS_ADDR, 32'h42);
    chk("lp", 1'b1, lowPower);
    host.rd(FSR_STATUS_ADDR, d, resp);
    chk("lp", 1'b0, lowPower);
    host.wr(FSR_STATUS_ADDR, 32'h42);
    chk("lp", 1'b1, lowPower);
    dataAccess <= 1'b1;
    @(posedge ref_clk);
    dataAccess <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("lp", 1'b0, lowPower);
    precompTrkIn <= rnd[7:0];
    precompSet <= 1'b1;
    @(posedge ref_clk);
    precompSet <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("track", rnd[7:0], precompTrack);
    host.wr(FSR_STATUS_ADDR, 32'h96);
    repeat (2) @(posedge ref_clk);
    chk("swcnt", 1, swCnt);
    chk("track", 8'h0, precompTrack);
    chk("shift", 3'h5, writeShiftCode);
    chk("rate", FSR_R250, rateSel);
    chk("dens", 1'b0, densityOutput);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("dens", 1'b1, densityOutput);
    chk("shift", 3'h3, writeShiftCode);
    results;
  end
endmodule // fsr_regs_tb
